// ---- rtl/rtm_regs.sv ----
// Reference trim and margin offset registers with ramped error-amp reference.
// Assumes link_req_valid is a one-cycle pulse on link_clk, ignored while link_busy is high;
// link_req is sampled on link_clk as well; all other inputs are synchronous to clk.
`timescale 1ns/100ps

// Behaviour
// - Signed trim offset is added to the error-amp reference target.
// - Store-all-defaults writes the trim offset out to nonvolatile storage.
// - Loop follower: offset access NACKed, writes dropped, fault flagged, alert raised.
// - Offsets use exponent minus nine, about 1.953 mV per step.
// - Trim offset accepts steps from minus 64 to plus 63.
// - Out-of-range write clamps to nearer limit, sets CML flags, raises alert.
// - Summed reference is bounded by the output maximum and minimum.
// - Reference ramps at the rate chosen by the converter state.
// - Trim offset is a two-byte two's complement value, default zero.
// - Trim low byte spans c0 to 3f, high byte is sign extension.
// - Margin High raises the reference by the margin-high offset.
// - Margin-high offset accepts steps from 0 to 31.
// - Margin-high keeps only a five-bit field; high byte reads zero.
// - Margin-high restores to 0009h or 000fh by high restore select.
// - Margin Low lowers the reference by the margin-low offset.
// - Margin-low offset accepts steps from minus 64 to minus 1.
// - Margin-low high byte stays all ones as sign extension.
// - Margin-low restores to fff7h or fff1h by low restore select.
module rtm_regs (
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic                        link_clk,
    input  wire logic                        link_req_valid,
    input  wire rtm_pkg::rtm_req_type        link_req,
    output logic                             link_busy,
    output logic                             link_resp_valid,
    output rtm_pkg::rtm_resp_type            link_resp,
    input  wire logic                        loop_follower,
    input  wire rtm_pkg::rtm_op_type         operation,
    input  wire rtm_pkg::rtm_conv_state_type conv_state,
    input  wire logic signed [15:0]          base_reference,
    input  wire logic signed [15:0]          vout_max,
    input  wire logic signed [15:0]          vout_min,
    input  wire logic [15:0]                 ton_rise_step,
    input  wire logic [15:0]                 transition_step,
    input  wire logic [15:0]                 toff_fall_step,
    input  wire logic                        store_all,
    input  wire logic                        restore_all,
    input  wire logic signed [15:0]          restore_trim_value,
    input  wire logic                        high_restore_select,
    input  wire logic                        low_restore_select,
    input  wire logic                        fault_clear,
    output logic signed [15:0]               error_amp_reference,
    output logic                             status_byte_cml,
    output logic                             status_cml_invalid_data,
    output logic                             invalid_command_fault,
    output logic                             smbalert_n,
    output logic                             nvm_trim_we,
    output logic [15:0]                      nvm_trim_data
);

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic out_of_range(input logic signed [15:0] v,
                                          input logic signed [15:0] lo,
                                          input logic signed [15:0] hi);
        out_of_range = (v < lo) || (v > hi);
    endfunction

    function automatic logic signed [15:0] clamp16(input logic signed [17:0] v,
                                                   input logic signed [15:0] lo,
                                                   input logic signed [15:0] hi);
        if (v < 18'(lo)) begin
            clamp16 = lo;
        end else if (v > 18'(hi)) begin
            clamp16 = hi;
        end else begin
            clamp16 = v[15:0];
        end
    endfunction

    // ************************************************************
    // Link domain: request capture and response return
    // ************************************************************
    rtm_pkg::rtm_req_type  lnk_req_q;
    rtm_pkg::rtm_resp_type lnk_resp_q;
    rtm_pkg::rtm_resp_type core_resp_q;
    logic lnk_req_tgl_q;
    logic lnk_busy_q;
    logic lnk_valid_q;
    logic lnk_ack_s1_q;
    logic lnk_ack_s2_q;
    logic lnk_ack_s3_q;
    logic core_ack_tgl_q;

    wire lnk_take      = link_req_valid & ~lnk_busy_q;
    wire lnk_ack_pulse = lnk_ack_s2_q ^ lnk_ack_s3_q;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lnk_ack_s1_q <= 1'b0;
            lnk_ack_s2_q <= 1'b0;
            lnk_ack_s3_q <= 1'b0;
        end else begin
            lnk_ack_s1_q <= core_ack_tgl_q;
            lnk_ack_s2_q <= lnk_ack_s1_q;
            lnk_ack_s3_q <= lnk_ack_s2_q;
        end
    end

    // Request word is held stable until the answer returns, so the core may read it directly
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lnk_req_q     <= '0;
            lnk_req_tgl_q <= 1'b0;
            lnk_busy_q    <= 1'b0;
        end else if (lnk_take) begin
            lnk_req_q     <= link_req;
            lnk_req_tgl_q <= ~lnk_req_tgl_q;
            lnk_busy_q    <= 1'b1;
        end else if (lnk_ack_pulse) begin
            lnk_busy_q    <= 1'b0;
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lnk_resp_q  <= '0;
            lnk_valid_q <= 1'b0;
        end else begin
            lnk_valid_q <= lnk_ack_pulse;
            if (lnk_ack_pulse) begin
                lnk_resp_q <= core_resp_q;
            end
        end
    end

    assign link_busy       = lnk_busy_q;
    assign link_resp_valid = lnk_valid_q;
    assign link_resp       = lnk_resp_q;

    // ************************************************************
    // Core domain: request decode
    // ************************************************************
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= lnk_req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    logic signed [15:0] trim_q;
    logic signed [15:0] mhi_q;
    logic signed [15:0] mlo_q;
    logic               cml_q;
    logic               inv_data_q;
    logic               ivc_q;

    wire req_pulse = req_s2_q ^ req_s3_q;
    wire hit_trim  = lnk_req_q.cmd == rtm_pkg::CMD_REF_TRIM;
    wire hit_mhi   = lnk_req_q.cmd == rtm_pkg::CMD_MARGIN_HIGH;
    wire hit_mlo   = lnk_req_q.cmd == rtm_pkg::CMD_MARGIN_LOW;
    wire hit_any   = hit_trim | hit_mhi | hit_mlo;
    wire refused   = req_pulse & hit_any & loop_follower;
    wire accepted  = req_pulse & hit_any & ~loop_follower;
    wire wr_ok     = accepted & lnk_req_q.write;
    wire wr_trim   = wr_ok & hit_trim;
    wire wr_mhi    = wr_ok & hit_mhi;
    wire wr_mlo    = wr_ok & hit_mlo;

    wire signed [15:0] wr_val  = lnk_req_q.data;
    wire               oor_w   = (wr_trim & out_of_range(wr_val, rtm_pkg::TRIM_MIN,
                                                          rtm_pkg::TRIM_MAX))
                               | (wr_mhi & out_of_range(wr_val, rtm_pkg::MHI_MIN,
                                                         rtm_pkg::MHI_MAX))
                               | (wr_mlo & out_of_range(wr_val, rtm_pkg::MLO_MIN,
                                                         rtm_pkg::MLO_MAX));

    // ************************************************************
    // Offset registers
    // ************************************************************
    // Restore outranks a write landing in the same cycle; clamping keeps the sign byte legal
    wire signed [15:0] trim_d = restore_all ? clamp16(18'(restore_trim_value), rtm_pkg::TRIM_MIN,
                                                      rtm_pkg::TRIM_MAX)
                              : wr_trim ? clamp16(18'(wr_val), rtm_pkg::TRIM_MIN,
                                                  rtm_pkg::TRIM_MAX)
                              : trim_q;
    wire signed [15:0] mhi_d  = restore_all ? (high_restore_select ? rtm_pkg::MHI_RESTORE_1
                                                                   : rtm_pkg::MHI_RESTORE_0)
                              : wr_mhi ? clamp16(18'(wr_val), rtm_pkg::MHI_MIN,
                                                 rtm_pkg::MHI_MAX)
                              : mhi_q;
    wire signed [15:0] mlo_d  = restore_all ? (low_restore_select ? rtm_pkg::MLO_RESTORE_1
                                                                  : rtm_pkg::MLO_RESTORE_0)
                              : wr_mlo ? clamp16(18'(wr_val), rtm_pkg::MLO_MIN,
                                                 rtm_pkg::MLO_MAX)
                              : mlo_q;

    // Margin offsets power up at their select-zero restore values
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_q <= rtm_pkg::TRIM_RESET;
            mhi_q  <= rtm_pkg::MHI_RESTORE_0;
            mlo_q  <= rtm_pkg::MLO_RESTORE_0;
        end else begin
            trim_q <= trim_d;
            mhi_q  <= mhi_d;
            mlo_q  <= mlo_d;
        end
    end

    // ************************************************************
    // Status flags and alert (set wins over clear)
    // ************************************************************
    wire cml_d      = oor_w | (cml_q & ~fault_clear);
    wire inv_data_d = oor_w | (inv_data_q & ~fault_clear);
    wire ivc_d      = refused | (ivc_q & ~fault_clear);
    wire alert_n_d  = ~(cml_d | inv_data_d | ivc_d);
    logic alert_n_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cml_q      <= 1'b0;
            inv_data_q <= 1'b0;
            ivc_q      <= 1'b0;
            alert_n_q  <= 1'b1;
        end else begin
            cml_q      <= cml_d;
            inv_data_q <= inv_data_d;
            ivc_q      <= ivc_d;
            alert_n_q  <= alert_n_d;
        end
    end

    assign status_byte_cml         = cml_q;
    assign status_cml_invalid_data = inv_data_q;
    assign invalid_command_fault   = ivc_q;
    assign smbalert_n              = alert_n_q;

    // ************************************************************
    // Response back to the link
    // ************************************************************
    wire [15:0] rd_data = hit_trim ? trim_q : hit_mhi ? mhi_q : hit_mlo ? mlo_q
                        : rtm_pkg::READ_ZERO;
    rtm_pkg::rtm_resp_type resp_d;
    assign resp_d.ack  = accepted;
    assign resp_d.data = (accepted & ~lnk_req_q.write) ? rd_data : rtm_pkg::READ_ZERO;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_resp_q    <= '0;
            core_ack_tgl_q <= 1'b0;
        end else if (req_pulse) begin
            core_resp_q    <= resp_d;
            core_ack_tgl_q <= ~core_ack_tgl_q;
        end
    end

    // ************************************************************
    // Nonvolatile store of the trim offset
    // ************************************************************
    logic        nvm_we_q;
    logic [15:0] nvm_data_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nvm_we_q   <= 1'b0;
            nvm_data_q <= rtm_pkg::READ_ZERO;
        end else begin
            nvm_we_q   <= store_all;
            nvm_data_q <= store_all ? trim_q : nvm_data_q;
        end
    end

    assign nvm_trim_we   = nvm_we_q;
    assign nvm_trim_data = nvm_data_q;

    // ************************************************************
    // Reference target and ramp
    // ************************************************************
    // Offsets share the reference LSB (2^-9 V), so they add without scaling
    wire signed [17:0] mhi_add = (operation == rtm_pkg::OP_MARGIN_HIGH) ? 18'(mhi_q)
                               : 18'sh0;
    wire signed [17:0] mlo_add = (operation == rtm_pkg::OP_MARGIN_LOW) ? 18'(mlo_q)
                               : 18'sh0;
    wire signed [17:0] ref_sum = 18'(base_reference) + 18'(trim_q)
                               + mhi_add + mlo_add;
    wire signed [15:0] target  = clamp16(ref_sum, vout_min, vout_max);

    logic [15:0] step;
    always_comb begin
        case (conv_state)
            rtm_pkg::CS_SOFT_START: step = ton_rise_step;
            rtm_pkg::CS_STEADY:     step = transition_step;
            rtm_pkg::CS_TOFF_DELAY: step = transition_step;
            rtm_pkg::CS_SOFT_STOP:  step = toff_fall_step;
            default:                step = 16'h0000;
        endcase
    end

    logic signed [15:0] ref_q;
    wire signed [17:0] gap    = 18'(target) - 18'(ref_q);
    wire signed [17:0] step_s = 18'({2'b00, step});
    wire signed [15:0] ref_d  = (gap > step_s) ? 16'(18'(ref_q) + step_s)
                              : (gap < -step_s) ? 16'(18'(ref_q) - step_s)
                              : target;
    wire               moving = step != 16'h0000;

    // Holding the reference when no rate applies avoids a jump while the converter is off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_q <= 16'sh0000;
        end else if (moving) begin
            ref_q <= ref_d;
        end
    end

    assign error_amp_reference = ref_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence follower_hit_s;
        req_pulse && hit_any && loop_follower;
    endsequence

    follower_nack_a: assert property (@(posedge clk) disable iff (!arst_n)
        follower_hit_s |=> !core_resp_q.ack && ivc_q ##1 !smbalert_n)
        else $error("follower access not refused");
    follower_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
        (follower_hit_s and !restore_all) |=> $stable(trim_q) && $stable(mhi_q) && $stable(mlo_q))
        else $error("follower write changed an offset");
    trim_range_a: assert property (@(posedge clk) disable iff (!arst_n)
        trim_q >= rtm_pkg::TRIM_MIN && trim_q <= rtm_pkg::TRIM_MAX)
        else $error("trim offset out of range");
    mhi_field_a: assert property (@(posedge clk) disable iff (!arst_n)
        mhi_q[15:5] == 11'h000)
        else $error("margin high carries bits above its field");
    mlo_sign_a: assert property (@(posedge clk) disable iff (!arst_n)
        mlo_q[15:6] == 10'h3ff)
        else $error("margin low lost its sign extension");
    clamp_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
        wr_trim && !restore_all && wr_val > rtm_pkg::TRIM_MAX
        |=> trim_q == rtm_pkg::TRIM_MAX && cml_q && inv_data_q ##1 !smbalert_n)
        else $error("out-of-range trim not clamped and flagged");
    restore_hi_a: assert property (@(posedge clk) disable iff (!arst_n)
        restore_all |=> mhi_q == ($past(high_restore_select) ? rtm_pkg::MHI_RESTORE_1
                                                              : rtm_pkg::MHI_RESTORE_0))
        else $error("margin high restore value wrong");
    restore_lo_a: assert property (@(posedge clk) disable iff (!arst_n)
        restore_all |=> mlo_q == ($past(low_restore_select) ? rtm_pkg::MLO_RESTORE_1
                                                             : rtm_pkg::MLO_RESTORE_0))
        else $error("margin low restore value wrong");
    store_trim_a: assert property (@(posedge clk) disable iff (!arst_n)
        store_all |=> nvm_trim_we && nvm_trim_data == $past(trim_q))
        else $error("trim not stored");
    margin_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        operation == rtm_pkg::OP_NOMINAL |-> ref_sum == 18'(base_reference) + 18'(trim_q))
        else $error("margin offset applied outside margin state");
    ramp_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        moving && gap > step_s |=> 18'(ref_q) == 18'($past(ref_q)) + $past(step_s))
        else $error("reference ramp step wrong");

endmodule

// ---- shared/rtm_pkg.sv ----
// Constants, types and the command map of the reference trim and margin offset bank.
// Assumes a PMBus frame layer in the link clock domain delivers decoded word commands.
package rtm_pkg;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] CMD_REF_TRIM    = 8'hd4;
    localparam logic [7:0] CMD_MARGIN_HIGH = 8'hd5;
    localparam logic [7:0] CMD_MARGIN_LOW  = 8'hd6;

    // ************************************************************
    // Reset, restore values and ranges (offset LSB = 2^-9 V)
    // ************************************************************
    localparam logic [4:0]         VOUT_MODE_EXP   = 5'h17;
    localparam logic signed [15:0] TRIM_RESET      = 16'sh0000;
    localparam logic signed [15:0] TRIM_MIN        = 16'shffc0;
    localparam logic signed [15:0] TRIM_MAX        = 16'sh003f;
    localparam logic signed [15:0] MHI_MIN         = 16'sh0000;
    localparam logic signed [15:0] MHI_MAX         = 16'sh001f;
    localparam logic signed [15:0] MLO_MIN         = 16'shffc0;
    localparam logic signed [15:0] MLO_MAX         = 16'shffff;
    localparam logic signed [15:0] MHI_RESTORE_0   = 16'sh0009;
    localparam logic signed [15:0] MHI_RESTORE_1   = 16'sh000f;
    localparam logic signed [15:0] MLO_RESTORE_0   = 16'shfff7;
    localparam logic signed [15:0] MLO_RESTORE_1   = 16'shfff1;
    localparam logic [15:0]        READ_ZERO       = 16'h0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        OP_NOMINAL     = 3'b001,
        OP_MARGIN_LOW  = 3'b010,
        OP_MARGIN_HIGH = 3'b100
    } rtm_op_type;

    typedef enum logic [4:0] {
        CS_OFF        = 5'b00001,
        CS_SOFT_START = 5'b00010,
        CS_STEADY     = 5'b00100,
        CS_TOFF_DELAY = 5'b01000,
        CS_SOFT_STOP  = 5'b10000
    } rtm_conv_state_type;

    typedef struct packed {
        logic        write;
        logic [7:0]  cmd;
        logic [15:0] data;
    } rtm_req_type;

    typedef struct packed {
        logic        ack;
        logic [15:0] data;
    } rtm_resp_type;

endpackage

// ---- test/rtm_host.sv ----
// Host-side model of the link: issues one word command, then waits for the answer.
// Assumes the block answers on link_clk with a one-cycle link_resp_valid.
`timescale 1ns/100ps
module rtm_host (
    input  wire logic                  link_clk,
    input  wire logic                  link_resp_valid,
    input  wire rtm_pkg::rtm_resp_type link_resp,
    output logic                       link_req_valid,
    output rtm_pkg::rtm_req_type       link_req
);
    initial begin
        link_req_valid = 1'b0;
        link_req = '0;
    end

    // Only one command outstanding, so busy never needs polling here
    task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] d,
                        output rtm_pkg::rtm_resp_type resp);
        int n;
        @(posedge link_clk);
        link_req_valid <= 1'b1;
        link_req <= '{write: wr, cmd: cmd, data: d};
        @(posedge link_clk);
        link_req_valid <= 1'b0;
        // Released lines show the inverse so stale data cannot pass for a request
        link_req <= ~link_req;
        resp = 'x;
        n = 0;
        while (n < 60) begin
            @(posedge link_clk);
            if (link_resp_valid === 1'b1) begin
                resp = link_resp;
                n = 60;
            end
            n++;
        end
    endtask
endmodule

// ---- test/tb_reference_trim_margin_regs.sv ----
// Self-checking bench of the trim and margin offset bank through the link host model.
// Assumes rtm_pkg, rtm_regs and rtm_host are compiled ahead of it.
`timescale 1ns/100ps
module tb_reference_trim_margin_regs;
    logic clk, link_clk, arst_n, link_req_valid, link_busy, link_resp_valid, loop_follower;
    logic store_all, restore_all, high_restore_select, low_restore_select, fault_clear;
    logic status_byte_cml, status_cml_invalid_data, invalid_command_fault, smbalert_n;
    logic nvm_trim_we;
    logic [15:0] ton_rise_step, transition_step, toff_fall_step, nvm_trim_data;
    logic signed [15:0] base_reference, vout_max, vout_min, restore_trim_value;
    logic signed [15:0] error_amp_reference;
    rtm_pkg::rtm_req_type link_req;
    rtm_pkg::rtm_resp_type link_resp, r;
    rtm_pkg::rtm_op_type operation;
    rtm_pkg::rtm_conv_state_type conv_state;
    int n_mismatch, checks, cyc;

    rtm_regs u_rtm_regs (.clk, .arst_n, .link_clk, .link_req_valid, .link_req, .link_busy,
        .link_resp_valid, .link_resp, .loop_follower, .operation, .conv_state, .base_reference,
        .vout_max, .vout_min, .ton_rise_step, .transition_step, .toff_fall_step, .store_all,
        .restore_all, .restore_trim_value, .high_restore_select, .low_restore_select,
        .fault_clear, .error_amp_reference, .status_byte_cml, .status_cml_invalid_data,
        .invalid_command_fault, .smbalert_n, .nvm_trim_we, .nvm_trim_data);
    rtm_host u_rtm_host (.link_clk, .link_resp_valid, .link_resp, .link_req_valid, .link_req);

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.1;
        forever #6 link_clk = ~link_clk;
    end
    // Cuts a hang short well past the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ********************
    // Shared tasks
    // ********************
    task automatic close_out();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] flags();
        return {12'h0, invalid_command_fault, status_byte_cml, status_cml_invalid_data, smbalert_n};
    endfunction
    // Read data is judged only on an acknowledged read
    task automatic rw(input logic wr, input logic [7:0] cmd, input logic [15:0] d,
                      input logic ack, input logic [15:0] exp);
        u_rtm_host.xfer(wr, cmd, d, r);
        chk("ack", 16'(ack), 16'(r.ack));
        chk("busy", 16'h0, 16'(link_busy));
        if (!wr && ack) begin
            chk("read data", exp, r.data);
        end
    endtask
    task automatic ramp(input rtm_pkg::rtm_conv_state_type st, input rtm_pkg::rtm_op_type op,
                        input logic [15:0] vmax, input logic [15:0] exp);
        int n;
        @(posedge clk);
        conv_state <= st;
        operation <= op;
        vout_max <= vmax;
        // Only the step of the current state is nonzero, so a wrong pick stalls the ramp
        ton_rise_step <= (st == rtm_pkg::CS_SOFT_START) ? 16'h4 : 16'h0;
        transition_step <= (st == rtm_pkg::CS_STEADY || st == rtm_pkg::CS_TOFF_DELAY) ? 16'h4
                                                                                     : 16'h0;
        toff_fall_step <= (st == rtm_pkg::CS_SOFT_STOP) ? 16'h4 : 16'h0;
        n = 0;
        while (error_amp_reference !== exp && n < 300) begin
            @(posedge clk);
            n++;
        end
        chk("reference", exp, error_amp_reference);
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_reset();
        rw(0, 8'hd4, 16'h0, 1, 16'h0000);
        rw(0, 8'hd5, 16'h0, 1, 16'h0009);
        rw(0, 8'hd6, 16'h0, 1, 16'hfff7);
        rw(0, 8'hd7, 16'h0, 0, 16'h0000);
    endtask
    task automatic t_range();
        rw(1, 8'hd4, 16'h003f, 1, 16'h0);
        rw(0, 8'hd4, 16'h0, 1, 16'h003f);
        chk("flags", 16'h1, flags());
        rw(1, 8'hd4, 16'h0040, 1, 16'h0);
        rw(0, 8'hd4, 16'h0, 1, 16'h003f);
        chk("flags", 16'h6, flags());
        rw(1, 8'hd4, 16'hff00, 1, 16'h0);
        rw(0, 8'hd4, 16'h0, 1, 16'hffc0);
        rw(1, 8'hd5, 16'h0020, 1, 16'h0);
        rw(0, 8'hd5, 16'h0, 1, 16'h001f);
        rw(1, 8'hd5, 16'hffff, 1, 16'h0);
        rw(0, 8'hd5, 16'h0, 1, 16'h0000);
        rw(1, 8'hd6, 16'h0000, 1, 16'h0);
        rw(0, 8'hd6, 16'h0, 1, 16'hffff);
        rw(1, 8'hd6, 16'hff80, 1, 16'h0);
        rw(0, 8'hd6, 16'h0, 1, 16'hffc0);
        rw(1, 8'hd5, 16'h001f, 1, 16'h0);
    endtask
    task automatic t_follower();
        @(posedge clk);
        fault_clear <= 1'b1;
        loop_follower <= 1'b1;
        @(posedge clk);
        fault_clear <= 1'b0;
        rw(1, 8'hd4, 16'h0011, 0, 16'h0);
        rw(0, 8'hd6, 16'h0, 0, 16'h0);
        chk("flags", 16'h8, flags());
        @(posedge clk);
        loop_follower <= 1'b0;
        rw(0, 8'hd4, 16'h0, 1, 16'hffc0);
    endtask
    task automatic t_ramp();
        ramp(rtm_pkg::CS_SOFT_START, rtm_pkg::OP_NOMINAL, 16'h7fff, 16'h00c0);
        ramp(rtm_pkg::CS_STEADY, rtm_pkg::OP_MARGIN_HIGH, 16'h7fff, 16'h00df);
        ramp(rtm_pkg::CS_SOFT_STOP, rtm_pkg::OP_MARGIN_LOW, 16'h7fff, 16'h0080);
        ramp(rtm_pkg::CS_STEADY, rtm_pkg::OP_MARGIN_HIGH, 16'h0090, 16'h0090);
        ramp(rtm_pkg::CS_TOFF_DELAY, rtm_pkg::OP_MARGIN_LOW, 16'h7fff, 16'h0080);
        ramp(rtm_pkg::CS_STEADY, rtm_pkg::OP_NOMINAL, 16'h7fff, 16'h00c0);
    endtask
    task automatic t_nvm();
        @(posedge clk);
        store_all <= 1'b1;
        @(posedge clk);
        store_all <= 1'b0;
        #1;
        chk("nvm write", 16'h1, 16'(nvm_trim_we));
        chk("nvm data", 16'hffc0, nvm_trim_data);
        for (int s = 1; s >= 0; s--) begin
            @(posedge clk);
            restore_all <= 1'b1;
            high_restore_select <= s[0];
            low_restore_select <= s[0];
            @(posedge clk);
            restore_all <= 1'b0;
            rw(0, 8'hd5, 16'h0, 1, s[0] ? 16'h000f : 16'h0009);
            rw(0, 8'hd6, 16'h0, 1, s[0] ? 16'hfff1 : 16'hfff7);
        end
    endtask

    initial begin
        {arst_n, loop_follower, store_all, restore_all, fault_clear} = '0;
        {high_restore_select, low_restore_select} = '0;
        {ton_rise_step, transition_step, toff_fall_step, restore_trim_value} = '0;
        operation = rtm_pkg::OP_NOMINAL;
        conv_state = rtm_pkg::CS_OFF;
        base_reference = 16'sh0100;
        vout_max = 16'sh7fff;
        vout_min = 16'sh8000;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_range();
        t_follower();
        t_ramp();
        t_nvm();
        close_out();
    end
endmodule
